// ===== rtl/smfs_pkg.sv
package smfs_pkg;
  localparam int CLK_HZ = 100_000_000;
  localparam int MS_CYC = CLK_HZ / 1000;
  localparam int MSW = 13;
  localparam int BLINK_HZ = 4;
  localparam int BLINK_MS = 1000 / (2 * BLINK_HZ);
  localparam int HOLD_S = 5;
  localparam int HOLD_MS = HOLD_S * 1000;
  localparam int EXIT_MS = 250;
  localparam int LINE_MS = 400;
  localparam int FPH_S = 2;
  localparam int FPH_MS = FPH_S * 1000;
  localparam int FLD_S = 6;
  localparam int FLD_MS = FLD_S * 1000;
  localparam int CHK_MS = 1000;
  localparam int SMP_MS = 50;
  localparam int HIST_S = 30;
  localparam int HIST_D = HIST_S * 1000 / SMP_MS;
  localparam int LOG_D = 100;
  localparam int CFG_W = 32;
  localparam int CH_N = 16;
  localparam int LOG_W = 4 + 32 + 32 + CFG_W;
  localparam int ID_MAX = 99_999_999;
  localparam int SY_W = CFG_W + 6;
  localparam int SY_SEAT = 5;
  localparam int SY_KEY = 4;
  localparam int SY_BTN = 3;
  localparam int SY_EXT = 2;
  localparam int SY_HI = 1;
  localparam int SY_LO = 0;
  localparam logic [SY_W-1:0] SY_RST = {32'h0, 6'h30};
  localparam logic [3:0] FT_CFG = 4'hC;
  localparam logic [3:0] FT_CARD = 4'hD;
  localparam logic [3:0] FT_KEY = 4'hE;
  typedef enum logic [3:0] {EV_FAULT, EV_PWRUP, EV_INTR, EV_REST, EV_RESET, EV_CFG} smfs_ev_e;
  typedef enum logic [1:0] {S_RUN, S_FLASH, S_EXIT} smfs_st_e;
  typedef struct packed {
    logic [3:0] typ;
    logic [CH_N-1:0] g;
    logic [CH_N-1:0] y;
    logic [CH_N-1:0] r;
    logic [CH_N-1:0] f;
    logic [7:0] tmp;
    logic [7:0] volt;
    logic [3:0] ctl;
  } smfs_rec_s;
  function automatic logic smfs_hit(input logic [MSW-1:0] c, input int n);
    return c == MSW'(n - 1);
  endfunction
endpackage

// ===== rtl/smfs_evlog.sv
`timescale 1ns/1ps
module smfs_evlog
  import smfs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic we,
  input wire logic [LOG_W-1:0] ent,
  input wire logic [6:0] rec,
  output logic [LOG_W-1:0] rd_data,
  output logic [6:0] cnt
);
  logic [LOG_W-1:0] mem_r [LOG_D];
  logic [6:0] wp_r, cnt_r;
  logic [7:0] d;
  logic [6:0] idx;
  // Storage has no reset, but a controller reset clears the count so older entries read back as zero
  always_ff @(posedge clk)
    if (we)
      mem_r[wp_r] <= ent;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
    begin
      wp_r <= 7'h0;
      cnt_r <= 7'h0;
    end
    else if (we)
    begin
      wp_r <= (wp_r == 7'(LOG_D - 1)) ? 7'h0 : wp_r + 7'h1;
      if (cnt_r != 7'(LOG_D))
        cnt_r <= cnt_r + 7'h1;
    end
  // Record 1 is the newest entry
  assign d = {1'b0, wp_r} + 8'(LOG_D) - {1'b0, rec};
  assign idx = (d >= 8'(LOG_D)) ? 7'(d - 8'(LOG_D)) : d[6:0];
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      rd_data <= '0;
    else
      rd_data <= (rec != 7'h0 && rec <= cnt_r) ? mem_r[idx] : '0;
  assign cnt = cnt_r;
endmodule // smfs_evlog

// ===== rtl/smfs_hist.sv
`timescale 1ns/1ps
module smfs_hist
  import smfs_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic smp,
  input wire logic frz,
  input wire logic [3*CH_N-1:0] din,
  input wire logic [9:0] age,
  output logic [3*CH_N-1:0] rd_data
);
  logic [3*CH_N-1:0] mem_r [HIST_D];
  logic [9:0] wp_r;
  logic [10:0] d;
  logic [9:0] idx;
  // Writing stops while a fault is latched, keeping the run-up to it
  always_ff @(posedge clk)
    if (smp && !frz)
      mem_r[wp_r] <= din;
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      wp_r <= 10'h0;
    else if (smp && !frz)
      wp_r <= (wp_r == 10'(HIST_D - 1)) ? 10'h0 : wp_r + 10'h1;
  assign d = {1'b0, wp_r} + 11'(HIST_D) - 11'h1 - {1'b0, age};
  assign idx = (d >= 11'(HIST_D)) ? 10'(d - 11'(HIST_D)) : d[9:0];
  // Slots never written since reset read back unknown; age 0 is newest
  always_ff @(posedge clk or negedge rst_n)
    if (!rst_n)
      rd_data <= '0;
    else
      rd_data <= (age < 10'(HIST_D)) ? mem_r[idx] : '0;
endmodule // smfs_hist

// ===== rtl/smfs_top.sv
`timescale 1ns/1ps
// How it works
// - Compare configuration at power-up, reset and each second; log any difference.
// - Configuration vector holds matrix, switches, jumpers and watchdog enable.
// - With change-fault option on, a change latches flash: relay off, hold on.
// - Configuration-change fault blinks the card-ajar indicator at 4 Hz.
// - Reset button held 5 s clears that fault and logs configuration reference.
// - With the option off a change is logged only, no fault.
// - Missing or loose card forces flash and lights card-ajar indicator.
// - Card fault stays latched until a reset command with card seated.
// - Key removed or invalid forces flash and lights key-error indicator.
// - Key read failure latches key error; clear needs valid key plus reset.
// - Leaving flash, hold drops 250 ms before the relay energizes.
// - Display shows live colors, or fault records while latched or browsing.
// - Latched display alternates fault channels 2 s and captured field 6 s.
// - Fault phase blinks all three colors of fault channels at 4 Hz.
// - Browse: each reset steps newest to older, flashes 1-3 times, wraps.
// - Key removed enters browse, reinserted exits; records are cleared by cold reset.
// - Event log keeps 100 stamped fault, line, reset and config entries.
// - Record 1 is newest; unit identifier limited to 0-99999999.
// - Line events are power-up, interruption and restore, with line voltage.
// - Config entries carry full set, changed-bit mask and time stamp.
// - Field history covers 30 s before a trigger at 50 ms steps.
// - Fault records keep type, field, fault channels, temperature, voltage, inputs.
// - Brownout restore needs line above restore level for 400 ms.
module smfs_top
  import smfs_pkg::*;
#(
  parameter int MS_CYC_P = MS_CYC
)
(
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic [CFG_W-1:0] CFG_IN,
  input wire logic CFG_FAULT_OPT,
  input wire logic CARD_SEATED,
  input wire logic KEY_PRESENT,
  input wire logic KEY_VALID,
  input wire logic KEY_READ_FAIL,
  input wire logic RESET_BTN,
  input wire logic EXT_RESET,
  input wire logic LINE_HI,
  input wire logic LINE_LO,
  input wire logic [7:0] LINE_VOLTS,
  input wire logic [7:0] TEMP,
  input wire logic [3:0] CTRL_IN,
  input wire logic [CH_N-1:0] FIELD_G,
  input wire logic [CH_N-1:0] FIELD_Y,
  input wire logic [CH_N-1:0] FIELD_R,
  input wire logic FAULT_IN,
  input wire logic [3:0] FAULT_CODE,
  input wire logic [CH_N-1:0] FAULT_CH,
  input wire logic [31:0] TIME_NOW,
  input wire logic ID_WE,
  input wire logic [26:0] ID_IN,
  input wire logic [6:0] LOG_REC,
  input wire logic [9:0] HIST_AGE,
  output logic RELAY_ENERGIZE,
  output logic HOLD_OUT,
  output logic CARD_AJAR_LED,
  output logic KEY_ERR_LED,
  output logic [CH_N-1:0] DISP_G,
  output logic [CH_N-1:0] DISP_Y,
  output logic [CH_N-1:0] DISP_R,
  output logic [3:0] REC_TYPE,
  output logic [7:0] REC_TEMP,
  output logic [7:0] REC_VOLTS,
  output logic [3:0] REC_CTRL,
  output logic [26:0] UNIT_ID,
  output logic [LOG_W-1:0] LOG_DATA,
  output logic [6:0] LOG_CNT,
  output logic [3*CH_N-1:0] HIST_DATA
);
  logic [1:0] rst_sy_r;
  logic rst_n;
  always_ff @(posedge CLK or negedge RST_B)
    if (!RST_B)
      rst_sy_r <= 2'h0;
    else
      rst_sy_r <= {rst_sy_r[0], 1'b1};
  assign rst_n = rst_sy_r[1];

  logic [SY_W-1:0] sy1_r, sy2_r;
  always_ff @(posedge CLK or negedge rst_n)
    if (!rst_n)
    begin
      sy1_r <= SY_RST;
      sy2_r <= SY_RST;
    end
    else
    begin
      sy1_r <= {CFG_IN, CARD_SEATED, KEY_PRESENT, RESET_BTN, EXT_RESET, LINE_HI, LINE_LO};
      sy2_r <= sy1_r;
    end
  logic [CFG_W-1:0] cfg_s;
  logic seated, present, btn, hi, lo;
  assign cfg_s = sy2_r[SY_W-1:6];
  assign seated = sy2_r[SY_SEAT];
  assign present = sy2_r[SY_KEY];
  assign btn = sy2_r[SY_BTN];
  assign hi = sy2_r[SY_HI];
  assign lo = sy2_r[SY_LO];

  logic btn_d_r, ext_d_r, pwr_r, pwr_d_r, rcmd_d_r, rst_cmd;
  assign rst_cmd = (btn && !btn_d_r) || (sy2_r[SY_EXT] && !ext_d_r);
  always_ff @(posedge CLK or negedge rst_n)
    if (!rst_n)
    begin
      btn_d_r <= 1'b0;
      ext_d_r <= 1'b0;
      pwr_r <= 1'b1;
      pwr_d_r <= 1'b0;
      rcmd_d_r <= 1'b0;
    end
    else
    begin
      btn_d_r <= btn;
      ext_d_r <= sy2_r[SY_EXT];
      pwr_r <= 1'b0;
      pwr_d_r <= pwr_r;
      rcmd_d_r <= rst_cmd;
    end

  // One millisecond tick shared by every timer
  logic [16:0] pre_r;
  logic ms;
  assign ms = pre_r == 17'(MS_CYC_P - 1);
  logic [MSW-1:0] blk_c_r, chk_c_r, smp_c_r;
  logic blink_r;
  logic [3:0] slot_r;
  logic blk_end, chk_due, smp;
  assign blk_end = ms && smfs_hit(blk_c_r, BLINK_MS);
  assign chk_due = ms && smfs_hit(chk_c_r, CHK_MS);
  assign smp = ms && smfs_hit(smp_c_r, SMP_MS);
  always_ff @(posedge CLK or negedge rst_n)
    if (!rst_n)
    begin
      pre_r <= 17'h0;
      blk_c_r <= '0;
      chk_c_r <= '0;
      smp_c_r <= '0;
      blink_r <= 1'b0;
      slot_r <= 4'h0;
    end
    else
    begin
      pre_r <= ms ? 17'h0 : pre_r + 17'h1;
      if (ms)
      begin
        blk_c_r <= blk_end ? '0 : blk_c_r + 13'h1;
        chk_c_r <= chk_due ? '0 : chk_c_r + 13'h1;
        smp_c_r <= smp ? '0 : smp_c_r + 13'h1;
      end
      if (blk_end)
      begin
        blink_r <= !blink_r;
        slot_r <= slot_r + 4'h1;
      end
    end

  // Stored copy is lost on cold reset, so the power-up check logs only
  logic [CFG_W-1:0] cfg_ref_r;
  logic [MSW-1:0] hold_c_r;
  logic cfg_flt_r, cfg_chg, cfg_set, cfg_clr;
  assign cfg_chg = (pwr_d_r || rcmd_d_r || chk_due) && (cfg_s != cfg_ref_r);
  assign cfg_set = cfg_chg && CFG_FAULT_OPT && !pwr_d_r;
  assign cfg_clr = cfg_flt_r && btn && ms && smfs_hit(hold_c_r, HOLD_MS);
  always_ff @(posedge CLK or negedge rst_n)
    if (!rst_n)
    begin
      cfg_ref_r <= '0;
      hold_c_r <= '0;
      cfg_flt_r <= 1'b0;
    end
    else
    begin
      if (cfg_chg || cfg_clr)
        cfg_ref_r <= cfg_s;
      if (!btn)
        hold_c_r <= '0;
      else if (ms)
        hold_c_r <= smfs_hit(hold_c_r, HOLD_MS) ? '0 : hold_c_r + 13'h1;
      if (cfg_set)
        cfg_flt_r <= 1'b1;
      else if (cfg_clr)
        cfg_flt_r <= 1'b0;
    end

  logic card_flt_r, key_flt_r, ext_flt_r, key_ok;
  logic [3:0] ext_code_r;
  logic [CH_N-1:0] ext_ch_r;
  assign key_ok = present && KEY_VALID && !KEY_READ_FAIL;
  always_ff @(posedge CLK or negedge rst_n)
    if (!rst_n)
    begin
      card_flt_r <= 1'b0;
      key_flt_r <= 1'b0;
      ext_flt_r <= 1'b0;
      ext_code_r <= 4'h0;
      ext_ch_r <= '0;
    end
    else
    begin
      if (!seated)
        card_flt_r <= 1'b1;
      else if (rst_cmd)
        card_flt_r <= 1'b0;
      if (!key_ok)
        key_flt_r <= 1'b1;
      else if (rst_cmd)
        key_flt_r <= 1'b0;
      if (FAULT_IN)
        ext_flt_r <= 1'b1;
      else if (rst_cmd)
        ext_flt_r <= 1'b0;
      if (FAULT_IN && !ext_flt_r)
      begin
        ext_code_r <= FAULT_CODE;
        ext_ch_r <= FAULT_CH;
      end
    end

  logic [MSW-1:0] lo_c_r, hi_c_r;
  logic brown_r, brn_set, brn_rest;
  assign brn_set = !brown_r && lo && ms && smfs_hit(lo_c_r, LINE_MS);
  assign brn_rest = brown_r && hi && ms && smfs_hit(hi_c_r, LINE_MS);
  always_ff @(posedge CLK or negedge rst_n)
    if (!rst_n)
    begin
      lo_c_r <= '0;
      hi_c_r <= '0;
      brown_r <= 1'b0;
    end
    else
    begin
      lo_c_r <= (!lo || brown_r || brn_set) ? '0 : lo_c_r + 13'(ms);
      hi_c_r <= (!hi || !brown_r || brn_rest) ? '0 : hi_c_r + 13'(ms);
      if (brn_set)
        brown_r <= 1'b1;
      else if (brn_rest)
        brown_r <= 1'b0;
    end

  chk_restore_time: assert property (@(posedge CLK) disable iff (!rst_n)
    $fell(brown_r) |-> $past(hi && hi_c_r == 13'(LINE_MS - 1)))
    else $error("restore taken before line was high long enough");

  logic [3:0] lat_v, lat_d_r, rise, new_typ;
  logic trig, fault_any, browse, show;
  assign lat_v = {ext_flt_r, key_flt_r, card_flt_r, cfg_flt_r};
  assign rise = lat_v & ~lat_d_r;
  assign trig = |rise;
  assign fault_any = |lat_v || brown_r;
  assign new_typ = rise[3] ? ext_code_r : rise[2] ? FT_KEY : rise[1] ? FT_CARD : FT_CFG;
  assign browse = !present;
  assign show = |lat_v || browse;

  smfs_st_e st_r, st_nxt;
  logic [MSW-1:0] ex_c_r;
  always_comb
  begin
    st_nxt = st_r;
    case (st_r)
      S_RUN:
        if (fault_any)
          st_nxt = S_FLASH;
      S_FLASH:
        if (!fault_any)
          st_nxt = S_EXIT;
      S_EXIT:
        if (fault_any)
          st_nxt = S_FLASH;
        else if (ms && smfs_hit(ex_c_r, EXIT_MS))
          st_nxt = S_RUN;
      default:
        st_nxt = S_FLASH;
    endcase
  end
  // Hold drops on entering S_EXIT; the relay waits out the lead time
  always_ff @(posedge CLK or negedge rst_n)
    if (!rst_n)
    begin
      st_r <= S_FLASH;
      ex_c_r <= '0;
      RELAY_ENERGIZE <= 1'b0;
      HOLD_OUT <= 1'b1;
    end
    else
    begin
      st_r <= st_nxt;
      ex_c_r <= (st_r != S_EXIT) ? '0 : ex_c_r + 13'(ms);
      RELAY_ENERGIZE <= st_nxt == S_RUN;
      HOLD_OUT <= st_nxt == S_FLASH;
    end

  chk_fault_flash: assert property (@(posedge CLK) disable iff (!rst_n)
    fault_any |=> !RELAY_ENERGIZE && HOLD_OUT)
    else $error("fault did not force flash");
  chk_exit_lead: assert property (@(posedge CLK) disable iff (!rst_n)
    $rose(RELAY_ENERGIZE) |-> $past(st_r == S_EXIT && ex_c_r == 13'(EXIT_MS - 1)) && !HOLD_OUT)
    else $error("relay energized without hold lead time");
  chk_card_clear: assert property (@(posedge CLK) disable iff (!rst_n)
    $fell(card_flt_r) |-> $past(rst_cmd && seated))
    else $error("card fault cleared without reset");
  chk_key_clear: assert property (@(posedge CLK) disable iff (!rst_n)
    $fell(key_flt_r) |-> $past(rst_cmd && key_ok))
    else $error("key fault cleared without valid key and reset");
  chk_cfg_clear: assert property (@(posedge CLK) disable iff (!rst_n)
    $fell(cfg_flt_r) |-> $past(btn && hold_c_r == 13'(HOLD_MS - 1)))
    else $error("config fault cleared before full hold");
  chk_cfg_opt_off: assert property (@(posedge CLK) disable iff (!rst_n)
    cfg_chg && !CFG_FAULT_OPT && !cfg_flt_r |=> !cfg_flt_r)
    else $error("config fault set with option off");
  cov_exit: cover property (@(posedge CLK) disable iff (!rst_n) $rose(RELAY_ENERGIZE));
  cov_cfg_clr: cover property (@(posedge CLK) disable iff (!rst_n) cfg_clr);

  logic [1:0] idx_r, sel;
  smfs_rec_s rec_r [3];
  smfs_rec_s cur;
  always_ff @(posedge CLK or negedge rst_n)
    if (!rst_n)
    begin
      lat_d_r <= 4'h0;
      idx_r <= 2'h0;
      for (int i = 0; i < 3; i++)
        rec_r[i] <= '0;
    end
    else
    begin
      lat_d_r <= lat_v;
      if (!browse)
        idx_r <= 2'h0;
      else if (rst_cmd)
        idx_r <= (idx_r == 2'h2) ? 2'h0 : idx_r + 2'h1;
      if (trig)
      begin
        rec_r[2] <= rec_r[1];
        rec_r[1] <= rec_r[0];
        rec_r[0] <= '{new_typ, FIELD_G, FIELD_Y, FIELD_R, rise[3] ? ext_ch_r : '0,
                      TEMP, LINE_VOLTS, CTRL_IN};
      end
    end
  assign sel = browse ? idx_r : 2'h0;
  assign cur = rec_r[sel];

  chk_browse_wrap: assert property (@(posedge CLK) disable iff (!rst_n)
    browse && rst_cmd && idx_r == 2'h2 ##1 browse |-> idx_r == 2'h0)
    else $error("browse index did not wrap to newest");
  cov_wrap: cover property (@(posedge CLK) disable iff (!rst_n) browse && rst_cmd && idx_r == 2'h2);

  logic ph_r;
  logic [MSW-1:0] ph_c_r;
  logic ph_end;
  assign ph_end = ms && smfs_hit(ph_c_r, ph_r ? FLD_MS : FPH_MS);
  always_ff @(posedge CLK or negedge rst_n)
    if (!rst_n)
    begin
      ph_r <= 1'b0;
      ph_c_r <= '0;
    end
    else if (!show || trig || (browse && rst_cmd))
    begin
      ph_r <= 1'b0;
      ph_c_r <= '0;
    end
    else if (ph_end)
    begin
      ph_r <= !ph_r;
      ph_c_r <= '0;
    end
    else
      ph_c_r <= ph_c_r + 13'(ms);

  chk_phase_len: assert property (@(posedge CLK) disable iff (!rst_n)
    $rose(ph_r) |-> $past(ph_c_r) == 13'(FPH_MS - 1))
    else $error("fault status phase length wrong");

  logic [CH_N-1:0] dg_r, dy_r, dr_r;
  always_ff @(posedge CLK or negedge rst_n)
    if (!rst_n)
    begin
      dg_r <= '0;
      dy_r <= '0;
      dr_r <= '0;
      CARD_AJAR_LED <= 1'b0;
      KEY_ERR_LED <= 1'b0;
    end
    else
    begin
      if (show && !ph_r)
      begin
        dg_r <= cur.f & {CH_N{blink_r}};
        dy_r <= cur.f & {CH_N{blink_r}};
        dr_r <= cur.f & {CH_N{blink_r}};
      end
      else
      begin
        dg_r <= show ? cur.g : FIELD_G;
        dy_r <= show ? cur.y : FIELD_Y;
        dr_r <= show ? cur.r : FIELD_R;
      end
      if (card_flt_r)
        CARD_AJAR_LED <= 1'b1;
      else if (cfg_flt_r)
        CARD_AJAR_LED <= blink_r;
      else if (browse)
        CARD_AJAR_LED <= !slot_r[0] && slot_r[3:1] <= {1'b0, idx_r};
      else
        CARD_AJAR_LED <= 1'b0;
      KEY_ERR_LED <= key_flt_r;
    end
  assign DISP_G = dg_r;
  assign DISP_Y = dy_r;
  assign DISP_R = dr_r;
  assign REC_TYPE = cur.typ;
  assign REC_TEMP = cur.tmp;
  assign REC_VOLTS = cur.volt;
  assign REC_CTRL = cur.ctl;

  chk_card_led: assert property (@(posedge CLK) disable iff (!rst_n)
    $past(card_flt_r) |-> CARD_AJAR_LED)
    else $error("card ajar indicator dark during card fault");

  // One entry per cycle; a lower-priority event in the same cycle is dropped
  smfs_ev_e log_typ;
  logic log_we;
  logic [31:0] log_dat;
  logic [CFG_W-1:0] log_msk;
  always_comb
  begin
    log_we = 1'b1;
    log_typ = EV_RESET;
    log_dat = 32'h0;
    log_msk = '0;
    if (trig)
    begin
      log_typ = EV_FAULT;
      log_dat = {28'h0, new_typ};
    end
    else if (cfg_chg || cfg_clr)
    begin
      log_typ = EV_CFG;
      log_dat = cfg_s;
      log_msk = cfg_chg ? cfg_s ^ cfg_ref_r : '0;
    end
    else if (brn_set || brn_rest || pwr_r)
    begin
      log_typ = pwr_r ? EV_PWRUP : brn_set ? EV_INTR : EV_REST;
      log_dat = {24'h0, LINE_VOLTS};
    end
    else
      log_we = rst_cmd && fault_any;
  end

  chk_cfg_log: assert property (@(posedge CLK) disable iff (!rst_n)
    cfg_chg && !trig |-> log_we && log_typ == EV_CFG && log_msk != '0)
    else $error("config change not logged");
  cov_fault: cover property (@(posedge CLK) disable iff (!rst_n) trig && rise[3]);

  logic [26:0] id_r;
  always_ff @(posedge CLK or negedge rst_n)
    if (!rst_n)
      id_r <= 27'h0;
    else if (ID_WE && ID_IN <= 27'(ID_MAX))
      id_r <= ID_IN;
  assign UNIT_ID = id_r;

  smfs_evlog u_log (
    .clk(CLK),
    .rst_n(rst_n),
    .we(log_we),
    .ent({log_typ, TIME_NOW, log_dat, log_msk}),
    .rec(LOG_REC),
    .rd_data(LOG_DATA),
    .cnt(LOG_CNT)
  );

  smfs_hist u_hist (
    .clk(CLK),
    .rst_n(rst_n),
    .smp(smp),
    .frz(|lat_v),
    .din({FIELD_G, FIELD_Y, FIELD_R}),
    .age(HIST_AGE),
    .rd_data(HIST_DATA)
  );
endmodule // smfs_top

// ===== bench/smfs_ctrl_model.sv
`timescale 1ns/1ps
module smfs_ctrl_model
(
  input wire logic clk,
  input wire logic hold,
  input wire logic relay,
  output int gap,
  output logic flash_on
);
  int run = 0;
  logic relay_q = 1'b0;
  // Cabinet runs flash whenever the output relay is dropped
  assign flash_on = !relay;
  // Stop time released counts up; latched as the cabinet leaves flash
  always @(posedge clk)
  begin
    relay_q <= relay;
    run <= hold ? 0 : run + 1;
    if (relay && !relay_q)
    begin
      gap <= run;
    end
  end
endmodule // smfs_ctrl_model

// ===== bench/signal_monitor_fault_supervisor_bench.sv
`timescale 1ns/1ps
`define CHK(g, e, m) check_count++; if ((g) !== (e)) begin error_cnt++; $display("ERROR %0t %s", $time, m); end
module signal_monitor_fault_supervisor_bench
  import smfs_pkg::*;
;
  logic clk = 1'b0, rst_b = 1'b0, cfg_opt = 1'b0, seated = 1'b1, key_on = 1'b1, key_ok = 1'b1;
  logic key_fail = 1'b0, btn = 1'b0, ext_rst = 1'b0, line_hi = 1'b1, line_lo = 1'b0;
  logic fault_in = 1'b0, id_we = 1'b0, relay, hold, card_led, key_led;
  logic [CFG_W-1:0] cfg = '0;
  logic [CH_N-1:0] fg = 16'h0001, fy = 16'h0002, fr = 16'h0004, fch = '0;
  logic [7:0] volts = 8'h78, temp = 8'h19;
  logic [3:0] ctl = 4'h1, fcode = 4'h1;
  logic [3:0] rec_type;
  logic [CH_N-1:0] dg, dy, dr;
  logic [3*CH_N-1:0] hist;
  logic [31:0] tnow = 32'h0000_1000;
  logic [26:0] id_in = '0, unit_id;
  logic [6:0] rec = 7'h01, log_cnt;
  logic [9:0] age = '0;
  logic [LOG_W-1:0] log_data;
  int error_cnt = 0, check_count = 0, cyc = 0, gap;
  // Short ms base keeps the 5 s hold inside the run budget
  smfs_top #(.MS_CYC_P(10)) u_dut (
    .CLK(clk), .RST_B(rst_b), .CFG_IN(cfg), .CFG_FAULT_OPT(cfg_opt), .CARD_SEATED(seated),
    .KEY_PRESENT(key_on), .KEY_VALID(key_ok), .KEY_READ_FAIL(key_fail), .RESET_BTN(btn),
    .EXT_RESET(ext_rst), .LINE_HI(line_hi), .LINE_LO(line_lo), .LINE_VOLTS(volts), .TEMP(temp),
    .CTRL_IN(ctl), .FIELD_G(fg), .FIELD_Y(fy), .FIELD_R(fr), .FAULT_IN(fault_in),
    .FAULT_CODE(fcode), .FAULT_CH(fch), .TIME_NOW(tnow), .ID_WE(id_we), .ID_IN(id_in),
    .LOG_REC(rec), .HIST_AGE(age), .RELAY_ENERGIZE(relay), .HOLD_OUT(hold),
    .CARD_AJAR_LED(card_led), .KEY_ERR_LED(key_led), .DISP_G(dg), .DISP_Y(dy), .DISP_R(dr),
    .REC_TYPE(rec_type), .REC_TEMP(), .REC_VOLTS(), .REC_CTRL(), .UNIT_ID(unit_id),
    .LOG_DATA(log_data), .LOG_CNT(log_cnt), .HIST_DATA(hist));
  smfs_ctrl_model u_ctrl (.clk(clk), .hold(hold), .relay(relay), .gap(gap), .flash_on());
  initial
  begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 98000)
    begin
      error_cnt++;
      $display("ERROR %0t run too long", $time);
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Reset command: button or external input, both synced inside
  task automatic press(input int n, input logic ext);
    btn = !ext;
    ext_rst = ext;
    tick(n);
    btn = 1'b0;
    ext_rst = 1'b0;
    tick(10);
  endtask
  task automatic wait_relay(input logic v);
    int k;
    k = 0;
    while (relay !== v && k < 9000)
    begin
      tick(1);
      k++;
    end
  endtask
  task automatic rd_log(input logic [6:0] r, output logic [LOG_W-1:0] d);
    rec = r;
    tick(2);
    d = log_data;
  endtask
  task automatic t_power();
    logic [LOG_W-1:0] d;
    wait_relay(1'b1);
    // The model latches the lead time one edge after the relay rises
    tick(1);
    `CHK({relay, hold}, 2'b10, "leave flash after power-up")
    `CHK(hist, {fg, fy, fr}, "newest history sample")
    `CHK(gap >= 2000 && gap <= 3000, 1'b1, "hold lead time")
    `CHK(log_cnt > 0, 1'b1, "log holds entries")
    rd_log(log_cnt, d);
    `CHK(d[LOG_W-1 -: 4], 4'(EV_PWRUP), "oldest is power-up")
    $display("test power-up done");
  endtask
  task automatic t_id();
    for (int i = 0; i < 2; i++)
    begin
      id_in = i ? 27'd100000000 : 27'd99999999;
      id_we = 1'b1;
      tick(1);
      id_we = 1'b0;
      tick(2);
      `CHK(unit_id, 27'd99999999, "unit id range")
    end
    $display("test unit id done");
  endtask
  // Card out, key invalid, key read failure; each latches until reset
  task automatic t_latch();
    logic [LOG_W-1:0] d;
    for (int i = 0; i < 3; i++)
    begin
      seated = (i != 0);
      key_ok = (i != 1);
      key_fail = (i == 2);
      tick(10);
      `CHK({relay, hold, card_led, key_led}, {2'b01, i == 0, i != 0}, "fault entered")
      seated = 1'b1;
      key_ok = 1'b1;
      key_fail = 1'b0;
      tick(50);
      `CHK({relay, card_led, key_led}, {1'b0, i == 0, i != 0}, "fault held")
      rd_log(7'd1, d);
      `CHK({d[LOG_W-1 -: 4], d[35:32]}, {4'(EV_FAULT), i ? FT_KEY : FT_CARD}, "fault entry")
      press(10, i == 1);
      wait_relay(1'b1);
      tick(1);
      `CHK({relay, card_led, key_led}, 3'b100, "fault cleared")
      `CHK(gap >= 2000 && gap <= 3000, 1'b1, "hold lead after reset")
      rd_log(7'd1, d);
      `CHK(d[LOG_W-1 -: 4], 4'(EV_RESET), "reset entry")
    end
    $display("test latches done");
  endtask
  task automatic t_cfg();
    logic [LOG_W-1:0] d;
    logic l0;
    int tg;
    cfg = 32'h0000_00A5;
    press(10, 1'b0);
    rd_log(7'd1, d);
    `CHK({d[LOG_W-1 -: 4], d[63:0]}, {4'(EV_CFG), 64'h0000_00A5_0000_00A5}, "change logged")
    `CHK(relay, 1'b1, "no fault with option off")
    cfg_opt = 1'b1;
    cfg = 32'h8000_00A5;
    press(10, 1'b0);
    `CHK({relay, hold}, 2'b01, "change fault")
    tg = 0;
    repeat (5000)
    begin
      l0 = card_led;
      tick(1);
      tg += (card_led !== l0);
    end
    `CHK(tg >= 3 && tg <= 5, 1'b1, "indicator blink rate")
    press(10, 1'b0);
    `CHK(relay, 1'b0, "short press keeps fault")
    btn = 1'b1;
    tick(48000);
    `CHK(hold, 1'b1, "fault before 5 s held")
    tick(2100);
    btn = 1'b0;
    rd_log(7'd1, d);
    `CHK({d[LOG_W-1 -: 4], d[63:0]}, {4'(EV_CFG), 64'h8000_00A5_0000_0000}, "reference logged")
    wait_relay(1'b1);
    `CHK(relay, 1'b1, "fault cleared by hold")
    $display("test configuration done");
  endtask
  // Brownout then restore; the exit sequence follows the restore
  task automatic t_line();
    logic [LOG_W-1:0] d;
    line_hi = 1'b0;
    line_lo = 1'b1;
    tick(4100);
    `CHK({relay, hold}, 2'b01, "brownout forces flash")
    line_lo = 1'b0;
    line_hi = 1'b1;
    tick(3900);
    `CHK({relay, hold}, 2'b01, "restore not before 400 ms")
    tick(200);
    `CHK(hold, 1'b0, "restore after 400 ms")
    rd_log(7'd2, d);
    `CHK({d[LOG_W-1 -: 4], d[63:32]}, {4'(EV_INTR), 32'h78}, "interruption entry")
    rd_log(7'd1, d);
    `CHK({d[LOG_W-1 -: 4], d[63:32]}, {4'(EV_REST), 32'h78}, "restore entry")
    wait_relay(1'b1);
    tick(1);
    `CHK(gap >= 2000 && gap <= 3000, 1'b1, "hold lead after restore")
    $display("test line done");
  endtask
  // External fault, then key removal browses the three newest records
  task automatic t_browse();
    logic [LOG_W-1:0] d;
    logic [3*CH_N-1:0] d0;
    fcode = 4'h3;
    fch = 16'h0008;
    fault_in = 1'b1;
    tick(10);
    rd_log(7'd1, d);
    `CHK({d[LOG_W-1 -: 4], d[35:32]}, {4'(EV_FAULT), 4'h3}, "external fault entry")
    d0 = {dg, dy, dr};
    tick(1250);
    `CHK({dg, dy, dr} ^ d0, {3{fch}}, "fault channels blink")
    fault_in = 1'b0;
    press(10, 1'b0);
    key_on = 1'b0;
    tick(10);
    fg = 16'h0010;
    tick(600);
    `CHK(hist, {16'h0001, fy, fr}, "history frozen while latched")
    for (int i = 0; i < 4; i++)
    begin
      `CHK(rec_type, i == 1 ? 4'h3 : i == 2 ? FT_CFG : FT_KEY, "browse record")
      press(10, 1'b0);
    end
    `CHK({relay, key_led}, 2'b01, "browse keeps key fault")
    $display("test browse done");
  endtask
  initial
  begin
    tick(4);
    rst_b = 1'b1;
    tick(3);
    t_power();
    t_id();
    t_latch();
    t_cfg();
    t_line();
    t_browse();
    wrap_up();
  end
endmodule // signal_monitor_fault_supervisor_bench
